// ### async_serial_receiver_recovery_tb.sv
// Testbench of the serial receiver: registers, reception, errors and wakeup
`timescale 1ns/1ps
`include "rx_recovery_consts.svh"

module async_serial_receiver_recovery_tb;
  logic        clk_sys = 1'b0;
  logic        rst     = 1'b1;
  logic        go      = 1'b0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [7:0]  fa      = 8'hFF;
  logic [31:0] wdata   = 32'h0;
  logic [3:0]  wstrb   = 4'h0;
  logic [3:0]  nb      = 4'h0;
  logic [1:0]  fl      = 2'h0;
  logic [11:0] frame   = 12'hFFF;
  logic        rx_pin, txb, awready, wready, bvalid, arready, rvalid, rx_irq;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata, rd;
  int          fails = 0;
  int          checks_done = 0;
  localparam logic [31:0] EN = 32'h1 << `CTRL_ENABLE;
  localparam logic [31:0] C9 = 32'h1 << `CTRL_CHAR9;
  localparam logic [31:0] WA = 32'h1 << `CTRL_WAKE_ADDR;
  localparam logic [31:0] QC = 32'h1 << `CTRL_QCSS;
  localparam logic [31:0] SB = 32'h1 << `CTRL_STANDBY;
  localparam logic [31:0] RIE = 32'h1 << `CTRL_RFIE;
  localparam logic [31:0] QIE = 32'h1 << `CTRL_LQIE;

  initial forever #12.5 clk_sys = ~clk_sys;

  rx_recovery dut (.clk_sys(clk_sys), .rst(rst), .rx_pin(rx_pin), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .rx_irq(rx_irq));
  serial_tx_model far (.clk_sys(clk_sys), .rst(rst), .go(go), .frame(frame), .nbits(nb), .flip_at(fa),
    .flip_len(fl), .rx_pin(rx_pin), .busy(txb));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rdreg(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic send(input logic [11:0] f, input logic [3:0] n, input logic [7:0] a, input logic [1:0] l);
    frame <= f;
    nb <= n;
    fa <= a;
    fl <= l;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    while (txb === 1'b1) @(posedge clk_sys);
  endtask

  function automatic logic [11:0] ch8(input logic [7:0] c);
    return {3'b111, c, 1'b0};
  endfunction

  // Status word: ninth, framing, noise, quiet, full
  function automatic logic [31:0] st(input logic rf, lq, nf, fe, n9);
    return {27'h0, n9, fe, nf, lq, rf};
  endfunction

  task automatic rx_check(input logic [31:0] sexp, input logic [7:0] dexp);
    rdreg(`STATUS_OFS);
    chk(rd & 32'h1D, sexp);
    rdreg(`DATA_OFS);
    chk(rd, {24'h0, dexp});
  endtask

  task automatic t_regs;
    rdreg(`CTRL_OFS);
    chk(rd, 32'h0);
    rdreg(`DIV_OFS);
    chk(rd, {16'h0, `DIV_RST});
    rdreg(8'h10);
    chk({30'h0, rs}, {30'h0, `RESP_SLVERR});
    wr(`DATA_OFS, 32'h5A);
    chk({30'h0, rs}, {30'h0, `RESP_SLVERR});
    wr(`DIV_OFS, 32'h0);
    chk({30'h0, rs}, {30'h0, `RESP_OKAY});
  endtask

  task automatic t_byte;
    wr(`CTRL_OFS, EN | RIE);
    send(ch8(8'hA5), 4'hA, 8'hFF, 2'h0);
    chk1(rx_irq, 1'b1);
    rx_check(st(1, 0, 0, 0, 1), 8'hA5);
  endtask

  // Single inverted sample at start tick 5, start tick 8, bit 3 mid and stop mid
  task automatic t_noise;
    logic [7:0] pos [4] = '{8'h05, 8'h08, 8'h38, 8'h98};
    foreach (pos[i]) begin
      send(ch8(8'h3C), 4'hA, pos[i], 2'h1);
      rx_check(st(1, 0, 1, 0, 0), 8'h3C);
    end
  endtask

  task automatic t_break;
    send(12'hC00, 4'hA, 8'hFF, 2'h0);
    rx_check(st(1, 0, 0, 1, 0), 8'h00);
  endtask

  task automatic t_badstart;
    send(12'hFFF, 4'h2, 8'h00, 2'h2);
    rdreg(`STATUS_OFS);
    chk(rd & 32'h1, 32'h0);
    send(ch8(8'h5A), 4'hA, 8'hFF, 2'h0);
    rx_check(st(1, 0, 0, 0, 0), 8'h5A);
  endtask

  task automatic t_nine;
    wr(`CTRL_OFS, EN | C9 | RIE);
    send({1'b1, 9'h15A, 1'b0}, 4'hB, 8'hFF, 2'h0);
    rx_check(st(1, 0, 0, 0, 1), 8'h5A);
  endtask

  task automatic t_addr;
    wr(`CTRL_OFS, EN | WA | SB | RIE);
    send(ch8(8'h12), 4'hA, 8'hFF, 2'h0);
    chk1(rx_irq, 1'b0);
    send(ch8(8'h85), 4'hA, 8'hFF, 2'h0);
    chk1(rx_irq, 1'b1);
    rdreg(`CTRL_OFS);
    chk(rd, EN | WA | RIE);
    wr(`CTRL_OFS, EN | WA | SB | RIE);
    repeat (2) @(posedge clk_sys);
    chk1(rx_irq, 1'b0);
    rx_check(st(1, 0, 0, 0, 1), 8'h85);
  endtask

  // Let the last character's quiet count expire, then start with the quiet flag clear
  task automatic t_idle;
    repeat (200) @(posedge clk_sys);
    wr(`CTRL_OFS, EN | SB);
    wr(`STATUS_OFS, 32'h2);
    send(ch8(8'h55), 4'hA, 8'hFF, 2'h0);
    repeat (250) @(posedge clk_sys);
    rdreg(`CTRL_OFS);
    chk(rd, EN);
    rdreg(`STATUS_OFS);
    chk(rd & 32'h3, 32'h0);
  endtask

  task automatic t_quiet;
    wr(`CTRL_OFS, EN | QC | QIE);
    send(ch8(8'h0F), 4'hA, 8'hFF, 2'h0);
    chk1(rx_irq, 1'b0);
    repeat (250) @(posedge clk_sys);
    chk1(rx_irq, 1'b1);
    rdreg(`STATUS_OFS);
    chk(rd & 32'h3, 32'h3);
    wr(`STATUS_OFS, 32'h2);
    rdreg(`DATA_OFS);
    repeat (2) @(posedge clk_sys);
    chk1(rx_irq, 1'b0);
  endtask

  task automatic wrap_up;
    $display("checks=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk_sys);
    fails++;
    wrap_up();
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_regs();
    t_byte();
    t_noise();
    t_break();
    t_badstart();
    t_nine();
    t_addr();
    t_idle();
    t_quiet();
    wrap_up();
  end
endmodule // async_serial_receiver_recovery_tb

// ### rx_recovery.sv
// Oversampled serial receive data recovery with standby, wakeup and an AXI4-Lite register slave
//
// Overview of operation
// - Line sampled on an oversample tick at sixteen times the baud rate.
// - Start search: low sample after three high samples starts the 16-tick count.
// - Start checked at ticks 3, 5, 7; two highs reject, one high sets noise.
// - Rejected start resets the tick count and restarts the search.
// - Data bit is the majority of ticks 8, 9, 10; disagreement sets noise.
// - High start samples at ticks 8 to 10 set noise, start still accepted.
// - Stop bit majority low sets framing error; disagreement sets noise.
// - Framing error is posted in the same cycle as receive-full.
// - A break character, lacking a high stop bit, sets framing error.
// - Tick count resynchronised on each start edge and on high-to-low bit change.
// - A falling edge after a high data bit resynchronises the tick count unless it falls at ticks 7 to 10.
// - Standby request suppresses receiver interrupt requests.
// - Address-mark wakeup: character with high MSB clears standby, sets receive-full.
// - Idle-line wakeup: idle clears standby and sets neither quiet nor full flag.
// - Quiet count start select: count ones after start bit or after stop bit.
// - Standby requested on an already idle line waits for a character and a new idle period.
// - Receive-full set on transfer to data buffer; interrupt when enabled.
// - Line-quiet flag after 10 or 11 high bits; interrupt when enabled.
// - Character length select chooses 8 or 9 bit reception.
// - Ninth bit captured in 9-bit mode; copy of bit 7 in 8-bit mode.
`timescale 1ns/1ps
`include "rx_recovery_consts.svh"

module rx_recovery (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic                 rx_pin,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [`ADDR_W-1:0]   awaddr,
  input  wire logic                 wvalid,
  output logic                      wready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  output logic                      bvalid,
  input  wire logic                 bready,
  output logic [1:0]                bresp,
  input  wire logic                 arvalid,
  output logic                      arready,
  input  wire logic [`ADDR_W-1:0]   araddr,
  output logic                      rvalid,
  input  wire logic                 rready,
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  output logic                      rx_irq
);
  import rx_recovery_pkg::*;

  rx_regs_t   q;
  rx_regs_t   d;
  logic       s;
  logic       maj;
  logic       disagree;
  logic [3:0] nbits;
  logic [3:0] quiet_thr;
  logic       stop_eval;
  logic       wake_mark;

  // Sample values seen at the current tick
  assign s         = q.rx_sync;
  assign maj       = (q.smp[1] & q.smp[0]) | (q.smp[1] & s) | (q.smp[0] & s);
  assign disagree  = (q.smp[1] | q.smp[0] | s) & ~(q.smp[1] & q.smp[0] & s);
  assign nbits     = q.char9 ? `BITS_9 : `BITS_8;
  assign quiet_thr = q.char9 ? `QUIET_9 : `QUIET_8;
  assign stop_eval = q.tick && q.st == ST_BITS && q.cnt == `OT_RT10 && q.bitn >= nbits;
  assign wake_mark = q.standby && q.wake_addr && q.shreg[8];

  always_comb begin
    d = q;
    d.rx_meta = rx_pin;
    d.rx_sync = q.rx_meta;

    // Oversample tick divider
    d.tick    = 1'b0;
    d.div_cnt = q.div_cnt + 16'h0001;
    if (q.div_cnt >= q.div) begin
      d.div_cnt = 16'h0000;
      d.tick    = q.enable;
    end

    // Write channel
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (awvalid && q.awready) begin
      d.aw_got = 1'b1;
      d.awaddr = awaddr;
    end
    if (wvalid && q.wready) begin
      d.w_got = 1'b1;
      d.wdata = wdata;
      d.wstrb = wstrb;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = `RESP_OKAY;
      if (q.awaddr == `CTRL_OFS) begin
        if (q.wstrb[0]) begin
          d.enable    = q.wdata[`CTRL_ENABLE];
          d.char9     = q.wdata[`CTRL_CHAR9];
          d.wake_addr = q.wdata[`CTRL_WAKE_ADDR];
          d.qcss      = q.wdata[`CTRL_QCSS];
          d.standby   = q.wdata[`CTRL_STANDBY];
          d.rfie      = q.wdata[`CTRL_RFIE];
          d.lqie      = q.wdata[`CTRL_LQIE];
        end
      end else if (q.awaddr == `STATUS_OFS) begin
        if (q.wstrb[0] && q.wdata[`ST_LQ]) begin
          d.lq = 1'b0;
        end
      end else if (q.awaddr == `DIV_OFS) begin
        if (q.wstrb[0]) begin
          d.div[7:0] = q.wdata[7:0];
        end
        if (q.wstrb[1]) begin
          d.div[15:8] = q.wdata[15:8];
        end
      end else begin
        d.bresp = `RESP_SLVERR;
      end
    end

    // Read channel; reading the data buffer clears the character flags
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp  = `RESP_OKAY;
      d.rdata  = 32'h0000_0000;
      if (araddr == `CTRL_OFS) begin
        d.rdata[`CTRL_ENABLE]    = q.enable;
        d.rdata[`CTRL_CHAR9]     = q.char9;
        d.rdata[`CTRL_WAKE_ADDR] = q.wake_addr;
        d.rdata[`CTRL_QCSS]      = q.qcss;
        d.rdata[`CTRL_STANDBY]   = q.standby;
        d.rdata[`CTRL_RFIE]      = q.rfie;
        d.rdata[`CTRL_LQIE]      = q.lqie;
      end else if (araddr == `STATUS_OFS) begin
        d.rdata[`ST_RF]    = q.rf;
        d.rdata[`ST_LQ]    = q.lq;
        d.rdata[`ST_NF]    = q.nf;
        d.rdata[`ST_FE]    = q.fe;
        d.rdata[`ST_NINTH] = q.ninth;
        d.rdata[`ST_BUSY]  = q.st != ST_IDLE;
      end else if (araddr == `DATA_OFS) begin
        d.rdata[7:0] = q.dbuf;
        d.rf         = 1'b0;
        d.nf         = 1'b0;
        d.fe         = 1'b0;
      end else if (araddr == `DIV_OFS) begin
        d.rdata[15:0] = q.div;
      end else begin
        d.rresp = `RESP_SLVERR;
      end
    end

    // Receiver; hardware sets come after the bus clears so that they win
    if (!q.enable) begin
      d.st   = ST_IDLE;
      d.hist = 3'h0;
      d.cnt  = 4'h0;
    end else if (q.tick) begin
      d.hist = {q.hist[1:0], s};
      d.cnt  = q.cnt + 4'h1;
      case (q.st)
        ST_IDLE: begin
          if (!s) begin
            d.ones = 4'h0;
          end else if (q.cnt == `OT_RT16 && q.ones != `ONES_MAX) begin
            d.ones = q.ones + 4'h1;
          end
          if (!s && q.hist == `HIST_IDLE) begin
            d.st     = ST_START;
            d.cnt    = 4'h0;
            d.nf_acc = 1'b0;
            d.bitn   = 4'h0;
            d.armed  = 1'b1;
            d.ones   = 4'h0;
          end
        end
        ST_START: begin
          if (q.cnt == `OT_RT3 || q.cnt == `OT_RT5 || q.cnt == `OT_RT8 || q.cnt == `OT_RT9) begin
            d.smp = {q.smp[0], s};
          end
          if (q.cnt == `OT_RT7) begin
            if (maj) begin
              d.st  = ST_IDLE;
              d.cnt = 4'h0;
            end else if (disagree) begin
              d.nf_acc = 1'b1;
            end
          end
          if (q.cnt >= `OT_RT8 && q.cnt <= `OT_RT10 && s) begin
            d.nf_acc = 1'b1;
          end
          if (q.cnt == `OT_RT16) begin
            d.st       = ST_BITS;
            d.last_bit = 1'b0;
          end
        end
        default: begin
          if (q.cnt == `OT_RT8 || q.cnt == `OT_RT9) begin
            d.smp = {q.smp[0], s};
          end
          if (q.cnt == `OT_RT16) begin
            d.bitn = q.bitn + 4'h1;
          end
          if (q.cnt == `OT_RT10) begin
            d.last_bit = maj;
            if (disagree) begin
              d.nf_acc = 1'b1;
            end
            if (!q.qcss) begin
              d.ones = maj ? ((q.ones == `ONES_MAX) ? q.ones : q.ones + 4'h1) : 4'h0;
            end
            if (q.bitn < nbits) begin
              d.shreg = {maj, q.shreg[8:1]};
            end else begin
              d.st   = ST_IDLE;
              d.hist = {3{maj}};
              if (!q.standby || wake_mark) begin
                d.rf    = 1'b1;
                d.nf    = q.nf | q.nf_acc | disagree;
                d.fe    = q.fe | ~maj;
                d.dbuf  = q.char9 ? q.shreg[7:0] : q.shreg[8:1];
                d.ninth = q.shreg[8];
              end
              if (wake_mark) begin
                d.standby = 1'b0;
              end
            end
          end else if (q.last_bit && !s && q.hist[0] && q.bitn < nbits) begin
            if (q.cnt >= `OT_RT11) begin
              d.cnt      = 4'h0;
              d.bitn     = q.bitn + 4'h1;
              d.last_bit = 1'b0;
            end else if (q.cnt <= `OT_RESYNC_LATE) begin
              d.cnt      = 4'h0;
              d.last_bit = 1'b0;
            end
          end
        end
      endcase
    end

    // Quiet line detection and idle wakeup
    if (q.armed && q.ones >= quiet_thr) begin
      d.armed = 1'b0;
      if (q.standby && !q.wake_addr) begin
        d.standby = 1'b0;
      end else begin
        d.lq = 1'b1;
      end
    end

    d.awready = !d.aw_got && !d.bvalid;
    d.wready  = !d.w_got && !d.bvalid;
    d.arready = !d.rvalid;
    d.irq     = !d.standby && ((d.rf && d.rfie) || (d.lq && d.lqie));
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q     <= '0;
      q.div <= `DIV_RST;
    end else begin
      q <= d;
    end
  end

  assign awready = q.awready;
  assign wready  = q.wready;
  assign bvalid  = q.bvalid;
  assign bresp   = q.bresp;
  assign arready = q.arready;
  assign rvalid  = q.rvalid;
  assign rdata   = q.rdata;
  assign rresp   = q.rresp;
  assign rx_irq  = q.irq;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  tick_spacing_a: assert property (q.tick && q.div != 16'h0000 |=> !q.tick)
    else $error("oversample tick on consecutive cycles");
  start_detect_a: assert property (q.enable && q.tick && q.st == ST_IDLE && !s && q.hist == `HIST_IDLE
    |=> q.st == ST_START && q.cnt == 4'h0 && !q.nf_acc)
    else $error("start edge not taken");
  start_reject_a: assert property (q.enable && q.tick && q.st == ST_START && q.cnt == `OT_RT7 && maj
    |=> q.st == ST_IDLE && q.cnt == 4'h0)
    else $error("bad start not rejected");
  start_noise_a: assert property (q.enable && q.tick && q.st == ST_START && q.cnt == `OT_RT7
    && disagree && !maj |=> q.nf_acc && q.st == ST_START)
    else $error("start noise not recorded");
  data_major_a: assert property (q.enable && q.tick && q.st == ST_BITS && q.cnt == `OT_RT10
    && q.bitn < nbits |=> q.shreg[8] == $past(maj) && (q.nf_acc || !$past(disagree)))
    else $error("data bit majority wrong");
  stop_post_a: assert property (q.enable && stop_eval && !q.standby
    |=> q.rf && (q.fe || $past(maj)) && q.st == ST_IDLE)
    else $error("stop bit not posted with flags");
  addr_wake_a: assert property (q.enable && stop_eval && wake_mark |=> !q.standby && q.rf)
    else $error("address mark did not wake");
  irq_gate_a: assert property (q.irq |-> !q.standby && ((q.rf && q.rfie) || (q.lq && q.lqie)))
    else $error("interrupt request without cause");
  quiet_wake_a: assert property ($rose(q.lq) |-> !$past(q.standby) || $past(q.wake_addr))
    else $error("waking idle set the quiet flag");

endmodule // rx_recovery

// ### rx_recovery_consts.svh
// Register offsets, field positions, reset values and sampling counts of the serial receiver
`ifndef RX_RECOVERY_CONSTS_SVH
`define RX_RECOVERY_CONSTS_SVH

`define ADDR_W          8
`define CTRL_OFS        8'h00
`define STATUS_OFS      8'h04
`define DATA_OFS        8'h08
`define DIV_OFS         8'h0C

`define CTRL_ENABLE     0
`define CTRL_CHAR9      1
`define CTRL_WAKE_ADDR  2
`define CTRL_QCSS       3
`define CTRL_STANDBY    4
`define CTRL_RFIE       5
`define CTRL_LQIE       6

`define ST_RF           0
`define ST_LQ           1
`define ST_NF           2
`define ST_FE           3
`define ST_NINTH        4
`define ST_BUSY         5

`define DIV_RST         16'h0103
`define OT_PER_BIT      16
`define OT_RT3          4'h2
`define OT_RT5          4'h4
`define OT_RT7          4'h6
`define OT_RT8          4'h7
`define OT_RT9          4'h8
`define OT_RT10         4'h9
`define OT_RT11         4'hA
`define OT_RT16         4'hF
`define OT_RESYNC_LATE  4'h5
`define BITS_8          4'h8
`define BITS_9          4'h9
`define QUIET_8         4'hA
`define QUIET_9         4'hB
`define ONES_MAX        4'hF
`define HIST_IDLE       3'h7
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ### rx_recovery_pkg.sv
// Types of the serial receiver: sampler states and the packed state record
package rx_recovery_pkg;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_BITS  = 2'b10
  } rx_state_t;

  typedef struct packed {
    logic        rx_meta;
    logic        rx_sync;
    rx_state_t   st;
    logic [15:0] div_cnt;
    logic        tick;
    logic [3:0]  cnt;
    logic [2:0]  hist;
    logic [1:0]  smp;
    logic [3:0]  bitn;
    logic [8:0]  shreg;
    logic        last_bit;
    logic        nf_acc;
    logic [3:0]  ones;
    logic        armed;
    logic        enable;
    logic        char9;
    logic        wake_addr;
    logic        qcss;
    logic        standby;
    logic        rfie;
    logic        lqie;
    logic [15:0] div;
    logic        rf;
    logic        lq;
    logic        nf;
    logic        fe;
    logic        ninth;
    logic [7:0]  dbuf;
    logic        irq;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rx_regs_t;

endpackage

// ### serial_tx_model.sv
// Remote serial transmitter model that drives the receive line
`timescale 1ns/1ps

module serial_tx_model (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic [11:0] frame,
  input  wire logic [3:0]  nbits,
  input  wire logic [7:0]  flip_at,
  input  wire logic [1:0]  flip_len,
  output logic             rx_pin,
  output logic             busy
);
  typedef struct packed {
    logic        busy;
    logic [7:0]  cnt;
    logic [11:0] sh;
  } tx_state_t;

  tx_state_t  s_q;
  tx_state_t  s_d;
  logic [7:0] last;

  // Each frame bit lasts 16 clocks, one oversample tick per clock
  assign last = {nbits - 4'h1, 4'hF};

  always_comb begin
    s_d = s_q;
    if (!s_q.busy && go) begin
      s_d.busy = 1'b1;
      s_d.cnt  = 8'h00;
      s_d.sh   = frame;
    end else if (s_q.busy) begin
      s_d.cnt = s_q.cnt + 8'h01;
      if (s_q.cnt == last) begin
        s_d.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Mark level between frames; the noise window inverts the line on command
  assign rx_pin = s_q.busy ? (s_q.sh[s_q.cnt[7:4]] ^ ((s_q.cnt - flip_at) < {6'h00, flip_len})) : 1'b1;
  assign busy   = s_q.busy;
endmodule // serial_tx_model
